/* File: djp_defs.vh */
`ifndef DJP_DEFS_VH
`define DJP_DEFS_VH

// configuration space offsets
`define DJP_CFG_POWER_CTRL   8'h22
`define DJP_CFG_ACTIVATE     8'h30
`define DJP_CFG_BASE_HIGH    8'h60
`define DJP_CFG_BASE_LOW     8'h61

// field positions
`define DJP_PWR_GAME_BIT     2
`define DJP_ACT_BIT          0

// reset values
`define DJP_STATUS_RST       8'h00
`define DJP_BASE_RST         8'h00
`define DJP_PWR_RST          8'h00

// system I/O offset of the status byte from the programmed base
`define DJP_STATUS_OFFSET    16'h0000

// discharge pulse on the rc pins after a trigger write
`define DJP_DISCHARGE_NS     1000
`define DJP_CLK_PERIOD_NS    4
`define DJP_DISCHARGE_CYC \
   ((`DJP_DISCHARGE_NS + `DJP_CLK_PERIOD_NS - 1) / `DJP_CLK_PERIOD_NS)
`define DJP_DCNT_W           9

`endif

/* File: djp_axis_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "djp_defs.vh"

// one axis timer channel: trigger starts a timing cycle, threshold ends it
module djp_axis_timer (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        trigger,
   input  wire        thresholdReached,
   output reg         axisTimerOut,
   output reg         rcDischarge
);

   // the count is worked out at integer width, then trimmed on purpose
   localparam integer           DISCHARGE_FULL = `DJP_DISCHARGE_CYC;
   localparam [`DJP_DCNT_W-1:0] DISCHARGE_LEN  =
      DISCHARGE_FULL[`DJP_DCNT_W-1:0];
   localparam [`DJP_DCNT_W-1:0] CNT_ONE        =
      {{(`DJP_DCNT_W-1){1'b0}}, 1'b1};

   reg [`DJP_DCNT_W-1:0] dischargeCnt_reg;
   reg                   pulseActive_reg;

   // the pin is held low until the next write after a timeout, so the
   // capacitor starts each measurement from empty
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         axisTimerOut     <= 1'b0;
         rcDischarge      <= 1'b0;
         dischargeCnt_reg <= {`DJP_DCNT_W{1'b0}};
         pulseActive_reg  <= 1'b0;
      end else if (trigger) begin
         rcDischarge      <= 1'b1;
         axisTimerOut     <= 1'b1;
         dischargeCnt_reg <= DISCHARGE_LEN;
         pulseActive_reg  <= 1'b1;
      end else if (pulseActive_reg) begin
         // threshold is ignored during the forced discharge
         if (dischargeCnt_reg == CNT_ONE) begin
            pulseActive_reg <= 1'b0;
            rcDischarge     <= 1'b0;
         end
         dischargeCnt_reg <= dischargeCnt_reg - CNT_ONE;
      end else if (axisTimerOut && thresholdReached) begin
         axisTimerOut <= 1'b0;
         rcDischarge  <= 1'b1;
      end
   end

endmodule

`default_nettype wire

/* File: djp_game_port.v */
// How it works
// - two joysticks, each with x and y timer channels and two buttons
// - status byte is read-only; a write only triggers the rc reset
// - bits 0-3 axis outputs stick one/two, bits 4-7 buttons
// - status reads 00h after power-on reset
// - any status write drives all rc pins of both sticks low
// - rc reset happens on the trailing edge of the write strobe
// - at threshold, axis output clears and its rc pin returns low
// - I/O read at programmed base returns current status byte
// - I/O write at programmed base is a trigger write
// - activate bit clear means the base address is not decoded
// - base address high byte at port_base_high, low byte at port_base_low
// - power control bit 2 and activate bit mirror each other
`timescale 1ns/1ps
`default_nettype none
`include "djp_defs.vh"

module djp_game_port (
   input  wire        clk,
   input  wire        rst_n,
   // host system I/O access, asynchronous strobes
   input  wire [15:0] ioAddr,
   input  wire        stickStatusRead_n,
   input  wire        stickTriggerWrite_n,
   output reg  [7:0]  ioRdData,
   output reg         ioRdHit,
   // configuration space access, synchronous
   input  wire [7:0]  cfgAddr,
   input  wire        cfgWrEn,
   input  wire [7:0]  cfgWrData,
   output reg  [7:0]  cfgRdData,
   // comparator outputs, high once rc input passes two thirds of vref
   input  wire        stickOneXThreshold,
   input  wire        stickOneYThreshold,
   input  wire        stickTwoXThreshold,
   input  wire        stickTwoYThreshold,
   // buttons, already level shifted
   input  wire        stickOneButtonOne,
   input  wire        stickOneButtonTwo,
   input  wire        stickTwoButtonOne,
   input  wire        stickTwoButtonTwo,
   // rc pins: open drain, only ever pulled low
   output reg         rcPinXOne,
   output reg         rcPinXOneOe,
   output reg         rcPinYOne,
   output reg         rcPinYOneOe,
   output reg         rcPinXTwo,
   output reg         rcPinXTwoOe,
   output reg         rcPinYTwo,
   output reg         rcPinYTwoOe,
   output reg         gamePortActive
);

   // decode of the base address, used for both reads and writes
   function baseHit;
      input [15:0] addr;
      input [15:0] base;
      input        active;
      begin
         baseHit = active && (addr == base + `DJP_STATUS_OFFSET);
      end
   endfunction

   reg  [7:0]  baseHigh_reg;
   reg  [7:0]  baseLow_reg;
   reg  [7:0]  powerCtrl_reg;
   reg         active_reg;
   reg  [15:0] addrSync1_reg;
   reg  [15:0] addrSync2_reg;
   reg  [1:0]  rdSync_reg;
   reg  [2:0]  wrSync_reg;
   reg  [3:0]  thrSync1_reg;
   reg  [3:0]  thrSync2_reg;
   reg  [3:0]  btnSync1_reg;
   reg  [3:0]  btnSync2_reg;
   wire [15:0] baseAddr;
   wire        rdActive;
   wire        wrTrailing;
   wire        writeHit;
   wire [3:0]  axisOut;
   wire [3:0]  rcDischarge;
   wire [7:0]  statusByte;

   assign baseAddr = {baseHigh_reg, baseLow_reg};
   assign rdActive = rdSync_reg[1];
   // strobe is active low: trailing edge is low then high
   assign wrTrailing = wrSync_reg[1] & ~wrSync_reg[2];
   assign writeHit = wrTrailing &&
                     baseHit(addrSync2_reg, baseAddr, active_reg);

   // status byte layout; nothing is stored, so a write alters it only by setting the axis bits
   assign statusByte = {btnSync2_reg[3], btnSync2_reg[2],
                        btnSync2_reg[1], btnSync2_reg[0],
                        axisOut[3], axisOut[2],
                        axisOut[1], axisOut[0]};

   // two-flop synchronisers for every pin-side input; the address is
   // quasi-static under the strobe so it shares the same latency
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addrSync1_reg <= 16'h0000;
         addrSync2_reg <= 16'h0000;
         rdSync_reg    <= 2'h0;
         wrSync_reg    <= 3'h7;
         thrSync1_reg  <= 4'h0;
         thrSync2_reg  <= 4'h0;
         btnSync1_reg  <= 4'h0;
         btnSync2_reg  <= 4'h0;
      end else begin
         addrSync1_reg <= ioAddr;
         addrSync2_reg <= addrSync1_reg;
         rdSync_reg    <= {rdSync_reg[0], ~stickStatusRead_n};
         wrSync_reg    <= {wrSync_reg[1:0], stickTriggerWrite_n};
         thrSync1_reg  <= {stickTwoYThreshold, stickTwoXThreshold,
                           stickOneYThreshold, stickOneXThreshold};
         thrSync2_reg  <= thrSync1_reg;
         btnSync1_reg  <= {stickTwoButtonTwo, stickTwoButtonOne,
                           stickOneButtonTwo, stickOneButtonOne};
         btnSync2_reg  <= btnSync1_reg;
      end
   end

   // configuration registers; the activate bit lives in one flop so both
   // views can never disagree
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baseHigh_reg  <= `DJP_BASE_RST;
         baseLow_reg   <= `DJP_BASE_RST;
         powerCtrl_reg <= `DJP_PWR_RST;
         active_reg    <= 1'b0;
      end else if (cfgWrEn) begin
         case (cfgAddr)
            `DJP_CFG_BASE_HIGH: baseHigh_reg <= cfgWrData;
            `DJP_CFG_BASE_LOW:  baseLow_reg  <= cfgWrData;
            `DJP_CFG_POWER_CTRL: begin
               powerCtrl_reg <= cfgWrData;
               active_reg    <= cfgWrData[`DJP_PWR_GAME_BIT];
            end
            `DJP_CFG_ACTIVATE: begin
               active_reg <= cfgWrData[`DJP_ACT_BIT];
            end
            default: ;
         endcase
      end
   end

   // configuration read-back, registered one cycle after the address
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfgRdData <= 8'h00;
      end else begin
         case (cfgAddr)
            `DJP_CFG_BASE_HIGH:  cfgRdData <= baseHigh_reg;
            `DJP_CFG_BASE_LOW:   cfgRdData <= baseLow_reg;
            `DJP_CFG_POWER_CTRL: begin
               cfgRdData <= powerCtrl_reg;
               cfgRdData[`DJP_PWR_GAME_BIT] <= active_reg;
            end
            `DJP_CFG_ACTIVATE: begin
               cfgRdData <= 8'h00;
               cfgRdData[`DJP_ACT_BIT] <= active_reg;
            end
            default: cfgRdData <= 8'h00;
         endcase
      end
   end

   // four identical axis channels
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1) begin : gAxis
         djp_axis_timer uAxis (
            .clk              (clk),
            .rst_n            (rst_n),
            .trigger          (writeHit),
            .thresholdReached (thrSync2_reg[i]),
            .axisTimerOut     (axisOut[i]),
            .rcDischarge      (rcDischarge[i])
         );
      end
   endgenerate

   // status read port; data follows the live status while the strobe
   // is held, so a long poll sees the axis bits fall
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ioRdData <= `DJP_STATUS_RST;
         ioRdHit  <= 1'b0;
      end else if (rdActive &&
                   baseHit(addrSync2_reg, baseAddr, active_reg)) begin
         ioRdData <= statusByte;
         ioRdHit  <= 1'b1;
      end else begin
         ioRdData <= `DJP_STATUS_RST;
         ioRdHit  <= 1'b0;
      end
   end

   // rc pins: driven low when discharging, released otherwise
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rcPinXOne      <= 1'b0;
         rcPinXOneOe    <= 1'b0;
         rcPinYOne      <= 1'b0;
         rcPinYOneOe    <= 1'b0;
         rcPinXTwo      <= 1'b0;
         rcPinXTwoOe    <= 1'b0;
         rcPinYTwo      <= 1'b0;
         rcPinYTwoOe    <= 1'b0;
         gamePortActive <= 1'b0;
      end else begin
         rcPinXOne      <= 1'b0;
         rcPinXOneOe    <= rcDischarge[0];
         rcPinYOne      <= 1'b0;
         rcPinYOneOe    <= rcDischarge[1];
         rcPinXTwo      <= 1'b0;
         rcPinXTwoOe    <= rcDischarge[2];
         rcPinYTwo      <= 1'b0;
         rcPinYTwoOe    <= rcDischarge[3];
         gamePortActive <= active_reg;
      end
   end

endmodule

`default_nettype wire

/* File: djp_game_port_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// watches decode, the config mirror and the stick-one x discharge pin
module djp_game_port_sva (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       stickStatusRead_n,
   input wire logic       stickTriggerWrite_n,
   input wire logic [7:0] ioRdData,
   input wire logic       ioRdHit,
   input wire logic [7:0] cfgAddr,
   input wire logic       cfgWrEn,
   input wire logic [7:0] cfgWrData,
   input wire logic       rcPinXOne,
   input wire logic       rcPinXOneOe,
   input wire logic       gamePortActive
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // a short discharge count or a leading-edge trigger fails here
   property p_pinLow; rcPinXOne == 1'b0; endproperty
   property p_rdIdle; stickStatusRead_n [*4] |-> !ioRdHit; endproperty
   property p_rdZero; !ioRdHit |-> ioRdData == 8'h00; endproperty
   property p_inactive; !gamePortActive [*5] |-> !ioRdHit; endproperty
   property p_actMirror; cfgWrEn && cfgAddr == 8'h30 ##1 !cfgWrEn |=>
      gamePortActive == $past(cfgWrData[0], 2); endproperty
   property p_pwrMirror; cfgWrEn && cfgAddr == 8'h22 ##1 !cfgWrEn |=>
      gamePortActive == $past(cfgWrData[2], 2); endproperty
   property p_discharge; $fell(rcPinXOneOe) |->
      $past(rcPinXOneOe, 250); endproperty
   property p_trailing; $rose(rcPinXOneOe) |->
      stickTriggerWrite_n && $past(stickTriggerWrite_n, 3); endproperty
   a_pinLow: assert property (p_pinLow) else $error("pin high");
   a_rdIdle: assert property (p_rdIdle) else $error("hit");
   a_rdZero: assert property (p_rdZero) else $error("data");
   a_inactive: assert property (p_inactive) else $error("hit");
   a_actMirror: assert property (p_actMirror) else $error("act");
   a_pwrMirror: assert property (p_pwrMirror) else $error("pwr");
   a_discharge: assert property (p_discharge)
      else $error("short");
   a_trailing: assert property (p_trailing) else $error("edge");
   // main scenarios reached
   c_read: cover property (ioRdHit);
   c_pulse: cover property ($fell(rcPinXOneOe));
   c_active: cover property ($rose(gamePortActive));
endmodule
bind djp_game_port djp_game_port_sva i_djp_game_port_sva (.clk, .rst_n,
   .stickStatusRead_n, .stickTriggerWrite_n, .ioRdData, .ioRdHit, .cfgAddr,
   .cfgWrEn, .cfgWrData, .rcPinXOne, .rcPinXOneOe, .gamePortActive);
`default_nettype wire

/* File: djp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host cpu: one strobe per access, address replaced by its complement afterwards
module djp_host_model (
   input  wire logic        clk,
   input  wire logic [7:0]  ioRdData,
   input  wire logic        ioRdHit,
   output var  logic [15:0] ioAddr,
   output var  logic        stickStatusRead_n,
   output var  logic        stickTriggerWrite_n
);
   // idle bus at time zero
   initial begin
      ioAddr = 16'hffff;
      stickStatusRead_n = 1'b1;
      stickTriggerWrite_n = 1'b1;
   end
   // write starts timing, reads poll it; data taken after the latency
   task automatic access(input logic w, input logic [15:0] a,
                         output logic [7:0] d, output logic h);
      @(posedge clk);
      ioAddr <= a;
      if (w) stickTriggerWrite_n <= 1'b0;
      else stickStatusRead_n <= 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      d = ioRdData;
      h = ioRdHit;
      @(posedge clk);
      stickTriggerWrite_n <= 1'b1;
      stickStatusRead_n <= 1'b1;
      repeat (4) @(posedge clk);
      ioAddr <= ~a; // a stale address is not left on the bus
   endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "djp_defs.vh"
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, cfgWrEn = 1'b0, h;
   logic [7:0]  cfgAddr = 8'h00, cfgWrData = 8'h00, d;
   logic [3:0]  thr = 4'h0, btn = 4'h0; // comparators and buttons
   int          n, nFail = 0, nTests = 0;
   wire  [15:0] ioAddr;
   wire  [7:0]  ioRdData, cfgRdData;
   wire  [3:0]  oe, pin;
   wire         stickStatusRead_n, stickTriggerWrite_n, ioRdHit;
   wire         gamePortActive;
   // 4 ns clock
   always #2 clk = ~clk;
   djp_game_port i_djp_game_port (.clk, .rst_n, .ioAddr,
      .stickStatusRead_n, .stickTriggerWrite_n, .ioRdData, .ioRdHit,
      .cfgAddr, .cfgWrEn, .cfgWrData, .cfgRdData,
      .stickOneXThreshold(thr[0]), .stickOneYThreshold(thr[1]),
      .stickTwoXThreshold(thr[2]), .stickTwoYThreshold(thr[3]),
      .stickOneButtonOne(btn[0]), .stickOneButtonTwo(btn[1]),
      .stickTwoButtonOne(btn[2]), .stickTwoButtonTwo(btn[3]),
      .rcPinXOne(pin[0]), .rcPinXOneOe(oe[0]), .rcPinYOne(pin[1]),
      .rcPinYOneOe(oe[1]), .rcPinXTwo(pin[2]), .rcPinXTwoOe(oe[2]),
      .rcPinYTwo(pin[3]), .rcPinYTwoOe(oe[3]), .gamePortActive);
   djp_host_model i_djp_host_model (.clk, .ioRdData, .ioRdHit, .ioAddr,
      .stickStatusRead_n, .stickTriggerWrite_n);
   // compare and count
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      nTests++;
      if (seen !== exp) begin
         nFail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // config access; read-back lands two edges after the address
   task automatic cfg(input logic [7:0] a, v, input logic we,
                      input logic [7:0] e);
      @(posedge clk);
      cfgAddr <= a;
      cfgWrEn <= we;
      cfgWrData <= v;
      @(posedge clk);
      cfgWrEn <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check({1'b0, cfgRdData}, {1'b0, e});
   endtask
   // bounded wait on the stick-one x discharge enable
   task automatic waitOe(input logic lvl);
      n = 0;
      while (oe[0] !== lvl && n < 400) begin
         @(negedge clk);
         n++;
      end
      check({8'h00, n >= 400}, 9'h000);
      if (n >= 400) conclude();
   endtask
   // host accesses go through the partner model
   task automatic wr(input logic [15:0] a);
      i_djp_host_model.access(1'b1, a, d, h);
   endtask
   task automatic rd(input logic [15:0] a, input logic [8:0] e);
      i_djp_host_model.access(1'b0, a, d, h);
      check({h, d}, e);
   endtask
   // base bytes, activate and power mirror, status after reset
   task automatic tCfg;
      cfg(8'h60, 8'h12, 1'b1, 8'h12);
      cfg(8'h61, 8'h34, 1'b1, 8'h34);
      cfg(8'h22, 8'h00, 1'b0, 8'h00);
      rd(16'h1234, 9'h000);
      cfg(8'h22, 8'h04, 1'b1, 8'h04);
      check({8'h00, gamePortActive}, 9'h001);
      cfg(8'h30, 8'h00, 1'b0, 8'h01);
      rd(16'h1234, 9'h100);
      $display("config test done");
   endtask
   // trigger, full discharge pulse, then each axis times out in turn
   task automatic tMeas;
      @(posedge clk);
      btn <= 4'hb;
      wr(16'h1234);
      waitOe(1'b1);
      check({5'h00, oe}, 9'h00f);
      check({5'h00, pin}, 9'h000);
      waitOe(1'b0);
      check(n[8:0], 9'(`DJP_DISCHARGE_CYC));
      rd(16'h1234, 9'h1bf);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         thr[i] <= 1'b1;
         rd(16'h1234, {1'b1, 4'hb, 4'hf << (i + 1)});
         check({5'h00, oe}, {5'h00, ~(4'hf << (i + 1))});
      end
      $display("measure test done");
   endtask
   // wrong address and an inactive port leave the timers alone
   task automatic tRefuse;
      wr(16'h1235);
      rd(16'h1234, 9'h1b0);
      rd(16'h1235, 9'h000);
      cfg(8'h30, 8'h00, 1'b1, 8'h00);
      check({8'h00, gamePortActive}, 9'h000);
      cfg(8'h22, 8'h00, 1'b0, 8'h00);
      @(posedge clk);
      thr <= 4'h0;
      wr(16'h1234);
      rd(16'h1234, 9'h000);
      cfg(8'h30, 8'h01, 1'b1, 8'h01);
      rd(16'h1234, 9'h1b0);
      wr(16'h1234);
      rd(16'h1234, 9'h1bf);
      $display("refusal test done");
   endtask
   // reset for 16 cycles, then the scenarios
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      tCfg();
      tMeas();
      tRefuse();
      conclude();
   end
endmodule
`default_nettype wire
